//--- hdl/dpbr_top.sv
// Dual-port 4,608-bit block RAM with FIFO, ROM and shift register modes.
`timescale 1ns/1ps
`include "dpbr_map.svh"
module dpbr_top
  import dpbr_pkg::*;
#(
  parameter int SR_W = `DPBR_SR_W,
  parameter int SR_LEN = `DPBR_SR_LEN,
  parameter int SR_TAPS = `DPBR_SR_TAPS
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic tick0_i,
  input wire logic tick1_i,
  input wire dpbr_cfg_t cfg_i,
  input wire logic ce_a_i,
  input wire logic clr_a_i,
  input wire logic oclr_a_i,
  input wire dpbr_req_t req_a_i,
  input wire logic ce_b_i,
  input wire logic clr_b_i,
  input wire logic oclr_b_i,
  input wire dpbr_req_t req_b_i,
  input wire logic load_we_i,
  input wire logic [6:0] load_row_i,
  input wire logic [35:0] load_data_i,
  output logic [35:0] q_a_o,
  output logic [35:0] q_b_o,
  output logic cfg_err_o,
  output logic fifo_full_o,
  output logic fifo_empty_o
);
  localparam int SR_WORD = SR_W * SR_TAPS;
  localparam logic SR_BAD = (SR_WORD > `DPBR_ROWW) || (SR_LEN > `DPBR_ROWS) || (SR_LEN < 1);
  localparam logic [6:0] SR_LAST = 7'(SR_LEN - 1);
  localparam logic [35:0] SR_MASK = 36'hf_ffff_ffff >> (`DPBR_ROWW - SR_WORD);
  localparam logic [35:0] SR_IN = 36'hf_ffff_ffff >> (`DPBR_ROWW - SR_W);

  // ****************************************************************
  // Shape helpers
  // ****************************************************************
  function automatic logic dpbr_is_par(input dpbr_wc_t wc);
    return (wc == DPBR_W9) || (wc == DPBR_W18) || (wc == DPBR_W36);
  endfunction

  function automatic logic dpbr_is_wide(input dpbr_wc_t wc);
    return (wc == DPBR_W32) || (wc == DPBR_W36);
  endfunction

  function automatic logic [12:0] dpbr_depth(input dpbr_wc_t wc);
    logic [12:0] d;
    unique case (wc)
      DPBR_W1: d = 13'h1000;
      DPBR_W2: d = 13'h0800;
      DPBR_W4: d = 13'h0400;
      DPBR_W8, DPBR_W9: d = 13'h0200;
      DPBR_W16, DPBR_W18: d = 13'h0100;
      DPBR_W32, DPBR_W36: d = 13'h0080;
      default: d = 13'h0000;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // Configuration check
  // ****************************************************************
  logic nxt_cfg_err;
  logic cfg_err_ff;
  logic mode_ram;
  logic fifo;
  logic shift;

  assign mode_ram = (cfg_i.mode == DPBR_M_TDP) || (cfg_i.mode == DPBR_M_SDP) ||
                    (cfg_i.mode == DPBR_M_SP);
  assign fifo = cfg_i.mode == DPBR_M_FIFO;
  assign shift = cfg_i.mode == DPBR_M_SHIFT;

  always_comb
  begin
    nxt_cfg_err = (cfg_i.wc_a > DPBR_W36) || (cfg_i.wc_b > DPBR_W36);
    unique case (cfg_i.mode)
      DPBR_M_TDP:
      begin
        nxt_cfg_err = nxt_cfg_err || dpbr_is_wide(cfg_i.wc_a) || dpbr_is_wide(cfg_i.wc_b);
        nxt_cfg_err = nxt_cfg_err || (dpbr_is_par(cfg_i.wc_a) != dpbr_is_par(cfg_i.wc_b));
      end
      DPBR_M_SDP:
        nxt_cfg_err = nxt_cfg_err || (dpbr_is_par(cfg_i.wc_a) != dpbr_is_par(cfg_i.wc_b));
      DPBR_M_FIFO:
        nxt_cfg_err = nxt_cfg_err || (cfg_i.wc_a != cfg_i.wc_b);
      DPBR_M_SHIFT:
        nxt_cfg_err = nxt_cfg_err || SR_BAD;
      DPBR_M_SP, DPBR_M_ROM: ;
      default:
        nxt_cfg_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_err_ff <= 1'b0;
    else if (en_i)
      cfg_err_ff <= nxt_cfg_err;
  end

  // ****************************************************************
  // Input registers
  // ****************************************************************
  logic [1:0] tick;
  logic cap_a;
  logic cap_b;
  dpbr_req_t ra_ff;
  dpbr_req_t rb_ff;
  logic pa_ff;
  logic pb_ff;
  logic csa_ff;
  logic csb_ff;

  assign tick = {tick1_i, tick0_i};
  assign cap_a = en_i && ce_a_i && tick[cfg_i.in_sel_a];
  assign cap_b = en_i && ce_b_i && tick[cfg_i.in_sel_b];

  // A clear leaves a marker so the read latch empties on the next edge.
  always_ff @(posedge clk_i or negedge nrst_i or posedge clr_a_i)
  begin
    if (!nrst_i)
    begin
      ra_ff <= '0;
      pa_ff <= 1'b0;
      csa_ff <= 1'b0;
    end
    else if (clr_a_i)
    begin
      ra_ff <= '0;
      pa_ff <= 1'b0;
      csa_ff <= 1'b1;
    end
    else if (en_i)
    begin
      csa_ff <= 1'b0;
      pa_ff <= cap_a;
      if (cap_a)
        ra_ff <= req_a_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i or posedge clr_b_i)
  begin
    if (!nrst_i)
    begin
      rb_ff <= '0;
      pb_ff <= 1'b0;
      csb_ff <= 1'b0;
    end
    else if (clr_b_i)
    begin
      rb_ff <= '0;
      pb_ff <= 1'b0;
      csb_ff <= 1'b1;
    end
    else if (en_i)
    begin
      csb_ff <= 1'b0;
      pb_ff <= cap_b;
      if (cap_b)
        rb_ff <= req_b_i;
    end
  end

  // ****************************************************************
  // Port operations
  // ****************************************************************
  logic op_a;
  logic op_b;
  logic a_wr;
  logic a_rd;
  logic b_wr;
  logic b_rd;
  logic fifo_full_ff;
  logic fifo_empty_ff;

  assign op_a = pa_ff && !cfg_err_ff;
  assign op_b = pb_ff && !cfg_err_ff;

  always_comb
  begin
    a_wr = 1'b0;
    a_rd = 1'b0;
    b_wr = 1'b0;
    b_rd = 1'b0;
    unique case (cfg_i.mode)
      DPBR_M_TDP:
      begin
        a_wr = op_a && ra_ff.we;
        a_rd = op_a && !ra_ff.we;
        b_wr = op_b && rb_ff.we;
        b_rd = op_b && !rb_ff.we;
      end
      DPBR_M_SDP:
      begin
        a_wr = op_a && ra_ff.we;
        b_rd = op_b && !rb_ff.we;
      end
      DPBR_M_SP:
      begin
        a_wr = op_a && ra_ff.we;
        a_rd = op_a && !ra_ff.we;
      end
      DPBR_M_FIFO:
      begin
        a_wr = op_a && ra_ff.we && !fifo_full_ff;
        b_rd = op_b && !rb_ff.we && !fifo_empty_ff;
      end
      DPBR_M_ROM:
      begin
        a_rd = op_a;
        b_rd = op_b;
      end
      DPBR_M_SHIFT:
      begin
        a_wr = op_a;
        a_rd = op_a;
      end
      default: ;
    endcase
  end

  // ****************************************************************
  // Storage array and lane mapping
  // ****************************************************************
  logic [35:0] mem [`DPBR_ROWS];
  logic [11:0] wptr_ff;
  logic [11:0] rptr_ff;
  logic [6:0] sr_ptr_ff;
  logic [6:0] row_a;
  logic [6:0] row_b;
  logic [35:0] mask_a;
  logic [35:0] mask_b;
  logic [35:0] data_a;
  logic [35:0] data_b;
  logic [35:0] rd_a;
  logic [35:0] rd_b;
  logic [6:0] wa_row;
  logic [35:0] wa_mask;
  logic [35:0] wa_data;
  logic [35:0] sr_old;

  dpbr_lane_map u_map_a (
    .wc_i(cfg_i.wc_a),
    .addr_i(fifo ? wptr_ff : ra_ff.addr),
    .be_i(ra_ff.be),
    .wd_i(ra_ff.wdata),
    .row_i(mem[row_a]),
    .row_o(row_a),
    .mask_o(mask_a),
    .data_o(data_a),
    .rd_o(rd_a)
  );

  dpbr_lane_map u_map_b (
    .wc_i(cfg_i.wc_b),
    .addr_i(fifo ? rptr_ff : rb_ff.addr),
    .be_i(rb_ff.be),
    .wd_i(rb_ff.wdata),
    .row_i(mem[row_b]),
    .row_o(row_b),
    .mask_o(mask_b),
    .data_o(data_b),
    .rd_o(rd_b)
  );

  // The shift row is read and rewritten in one edge, so each tap moves one place.
  assign sr_old = mem[sr_ptr_ff] & SR_MASK;
  assign wa_row = shift ? sr_ptr_ff : row_a;
  assign wa_mask = shift ? SR_MASK : mask_a;
  assign wa_data = shift ? (((sr_old << SR_W) | (ra_ff.wdata & SR_IN)) & SR_MASK) : data_a;

  // Same-row writes from both ports in one edge leave port B's word.
  always_ff @(posedge clk_i)
  begin
    if (en_i)
    begin
      if (load_we_i && !fifo && !shift)
        mem[load_row_i] <= load_data_i;
      else
      begin
        if (a_wr)
          mem[wa_row] <= (mem[wa_row] & ~wa_mask) | (wa_data & wa_mask);
        if (b_wr)
          mem[row_b] <= (mem[row_b] & ~mask_b) | (data_b & mask_b);
      end
    end
  end

  // ****************************************************************
  // FIFO and shift pointers
  // ****************************************************************
  logic push;
  logic pop;
  logic [12:0] depth;
  logic [12:0] cnt_ff;
  logic [12:0] nxt_cnt;

  assign push = fifo && a_wr;
  assign pop = fifo && b_rd;
  assign depth = dpbr_depth(cfg_i.wc_a);
  assign nxt_cnt = cnt_ff + {12'h000, push} - {12'h000, pop};

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wptr_ff <= 12'h000;
      rptr_ff <= 12'h000;
      cnt_ff <= 13'h0000;
      fifo_full_ff <= 1'b0;
      fifo_empty_ff <= 1'b1;
    end
    else if (en_i)
    begin
      if (!fifo)
      begin
        wptr_ff <= 12'h000;
        rptr_ff <= 12'h000;
        cnt_ff <= 13'h0000;
        fifo_full_ff <= 1'b0;
        fifo_empty_ff <= 1'b1;
      end
      else
      begin
        if (push)
          wptr_ff <= ({1'b0, wptr_ff} + 13'h0001 == depth) ? 12'h000 : wptr_ff + 12'h001;
        if (pop)
          rptr_ff <= ({1'b0, rptr_ff} + 13'h0001 == depth) ? 12'h000 : rptr_ff + 12'h001;
        cnt_ff <= nxt_cnt;
        fifo_full_ff <= nxt_cnt == depth;
        fifo_empty_ff <= nxt_cnt == 13'h0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sr_ptr_ff <= 7'h00;
    else if (en_i && shift && a_wr)
      sr_ptr_ff <= (sr_ptr_ff == SR_LAST) ? 7'h00 : sr_ptr_ff + 7'h01;
  end

  // ****************************************************************
  // Read latches and output stages
  // ****************************************************************
  logic ld_a;
  logic ld_b;
  logic [35:0] lat_a_nxt;
  logic [35:0] lat_b_nxt;
  logic [35:0] lat_a_ff;
  logic [35:0] lat_b_ff;

  assign ld_a = en_i && (csa_ff || a_rd);
  assign ld_b = en_i && (csb_ff || b_rd);
  assign lat_a_nxt = csa_ff ? 36'h0 : (shift ? sr_old : rd_a);
  assign lat_b_nxt = csb_ff ? 36'h0 : rd_b;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lat_a_ff <= 36'h0;
      lat_b_ff <= 36'h0;
    end
    else
    begin
      if (ld_a)
        lat_a_ff <= lat_a_nxt;
      if (ld_b)
        lat_b_ff <= lat_b_nxt;
    end
  end

  dpbr_out_stage #(.W(36)) u_out_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .clr_i(oclr_a_i),
    .byp_i(cfg_i.byp_a),
    .ld_i(ld_a),
    .tick_i(tick[cfg_i.out_sel_a]),
    .d_i(lat_a_nxt),
    .lat_i(lat_a_ff),
    .q_o(q_a_o)
  );

  dpbr_out_stage #(.W(36)) u_out_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .clr_i(oclr_b_i),
    .byp_i(cfg_i.byp_b),
    .ld_i(ld_b),
    .tick_i(tick[cfg_i.out_sel_b]),
    .d_i(lat_b_nxt),
    .lat_i(lat_b_ff),
    .q_o(q_b_o)
  );

  assign cfg_err_o = cfg_err_ff;
  assign fifo_full_o = fifo_full_ff;
  assign fifo_empty_o = fifo_empty_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_ce_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && !ce_a_i) |=> (!pa_ff && !a_wr))
    else $error("port A acted with clock enable low");

  chk_in_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_a_i |-> (ra_ff == '0 && !pa_ff))
    else $error("input clear did not empty port A registers");

  chk_clr_next: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(clr_a_i) && en_i) |=> (lat_a_ff == 36'h0))
    else $error("input clear not seen at next edge");

  chk_out_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    oclr_a_i |-> (q_a_o == 36'h0))
    else $error("output clear did not act");

  chk_out_clear_b: assert property (@(posedge clk_i) disable iff (!nrst_i)
    oclr_b_i |-> (q_b_o == 36'h0))
    else $error("output clear did not act on port B");

  chk_tdp_wide: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && cfg_i.mode == DPBR_M_TDP && dpbr_is_wide(cfg_i.wc_a)) |=> cfg_err_ff)
    else $error("wide shape accepted in true dual-port mode");

  chk_par_pair: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && cfg_i.mode == DPBR_M_SDP &&
     dpbr_is_par(cfg_i.wc_a) != dpbr_is_par(cfg_i.wc_b)) |=> cfg_err_ff)
    else $error("parity and plain widths paired");

  chk_rom_nowr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cfg_i.mode == DPBR_M_ROM) |-> (!a_wr && !b_wr))
    else $error("write in read-only mode");

  chk_byp_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ld_a && cfg_i.byp_a && !oclr_a_i) |=> (oclr_a_i || q_a_o == $past(lat_a_nxt)))
    else $error("bypassed output did not follow the array");

  chk_sr_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && shift && a_wr) |=>
      (sr_ptr_ff == (($past(sr_ptr_ff) == SR_LAST) ? 7'h00 : $past(sr_ptr_ff) + 7'h01)))
    else $error("shift position did not advance by one");

  chk_fifo_full: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fifo_full_ff |-> !push)
    else $error("push into full FIFO");
endmodule

//--- hdl/dpbr_map.svh
// Constants of the dual-port block RAM: capacity, geometry and shift register shape.
// Functional notes
// - The array holds exactly 4,608 bits including parity; every shape fits.
// - Modes are true dual-port, simple dual-port, single-port, FIFO, ROM, shift register.
// - In RAM or ROM mode contents load from an image before operation.
// - Port shapes are 4Kx1, 2Kx2, 1Kx4, 512x8/9, 256x16/18, 128x32/36.
// - True dual-port mode forbids the 128-deep 32- or 36-bit shape.
// - Ports may use different widths over one storage, addresses scaled per width.
// - Widths without parity pair only together; parity widths pair only together. ROM, single-port and shift register modes do not check the pairing.
// - Shift register width times tap length times taps stays within 4,608 bits.
// - Byte-masked writes only at write widths 16, 18, 32, 36; narrower write whole.
// - Bytes with enable low keep their old value during a masked write.
// - Enable 0 gates bits 8..0, 1 bits 17..9, 2 bits 26..18, 3 bits 35..27.
// - Any byte enable combination, all or none included, applies lane by lane.
// - In 16- and 32-bit widths enables gate 8-bit lanes in the same order.
// - The block accepts two independent clocks for inputs and outputs; here one clk_i with tick0_i and tick1_i enables serves both.
// - Input and output registers each run on either block clock, as configured.
// - The output register may be bypassed; input registers always stay in the path.
// - Input clear acts at once, seen at output next edge; output clear acts at once. Without bypass, q shows the input clear at the second edge.
// - Shift mode reads then writes each location, one position per clock.
// - Parity widths carry one extra bit per byte for parity or user control.
`ifndef DPBR_MAP_SVH
`define DPBR_MAP_SVH
`define DPBR_BITS 4608
`define DPBR_ROWS 128
`define DPBR_ROWW 36
`define DPBR_LANEW 9
`define DPBR_ADDRW 12
`define DPBR_SR_W 4
`define DPBR_SR_LEN 128
`define DPBR_SR_TAPS 9
`endif

//--- hdl/dpbr_pkg.sv
// Types shared by the dual-port block RAM modules.
package dpbr_pkg;
  typedef enum logic [2:0] {
    DPBR_M_TDP = 3'h0,
    DPBR_M_SDP = 3'h1,
    DPBR_M_SP = 3'h2,
    DPBR_M_FIFO = 3'h3,
    DPBR_M_ROM = 3'h4,
    DPBR_M_SHIFT = 3'h5
  } dpbr_mode_t;
  typedef enum logic [3:0] {
    DPBR_W1 = 4'h0,
    DPBR_W2 = 4'h1,
    DPBR_W4 = 4'h2,
    DPBR_W8 = 4'h3,
    DPBR_W9 = 4'h4,
    DPBR_W16 = 4'h5,
    DPBR_W18 = 4'h6,
    DPBR_W32 = 4'h7,
    DPBR_W36 = 4'h8
  } dpbr_wc_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [3:0] be;
    logic [35:0] wdata;
  } dpbr_req_t;
  typedef struct packed {
    dpbr_mode_t mode;
    dpbr_wc_t wc_a;
    dpbr_wc_t wc_b;
    logic in_sel_a;
    logic in_sel_b;
    logic out_sel_a;
    logic out_sel_b;
    logic byp_a;
    logic byp_b;
  } dpbr_cfg_t;
endpackage

//--- hdl/dpbr_lane_map.sv
// Maps a port address and width onto a storage row, lane mask and data.
`timescale 1ns/1ps
module dpbr_lane_map
  import dpbr_pkg::*;
(
  input wire dpbr_wc_t wc_i,
  input wire logic [11:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [35:0] wd_i,
  input wire logic [35:0] row_i,
  output logic [6:0] row_o,
  output logic [35:0] mask_o,
  output logic [35:0] data_o,
  output logic [35:0] rd_o
);
  logic [1:0] lane;
  logic [2:0] bo;
  logic [35:0] nm;
  logic multi;
  logic par;
  logic four;
  logic [5:0] off;
  int k;
  int ew;

  always_comb
  begin
    row_o = 7'h00;
    lane = 2'h0;
    bo = 3'h0;
    nm = 36'h0;
    multi = 1'b0;
    par = 1'b0;
    four = 1'b0;
    k = 0;
    ew = 8;
    // Rows are nine-bit lanes; narrower shapes index bits inside a lane.
    unique case (wc_i)
      DPBR_W1: begin row_o = addr_i[11:5]; lane = addr_i[4:3]; bo = addr_i[2:0]; nm = 36'h1; end
      DPBR_W2: begin row_o = addr_i[10:4]; lane = addr_i[3:2]; bo = {addr_i[1:0], 1'b0}; nm = 36'h3; end
      DPBR_W4: begin row_o = addr_i[9:3]; lane = addr_i[2:1]; bo = {addr_i[0], 2'h0}; nm = 36'hf; end
      DPBR_W8: begin row_o = addr_i[8:2]; lane = addr_i[1:0]; nm = 36'hff; end
      DPBR_W9: begin row_o = addr_i[8:2]; lane = addr_i[1:0]; nm = 36'h1ff; end
      DPBR_W16: begin row_o = addr_i[7:1]; lane = {addr_i[0], 1'b0}; multi = 1'b1; end
      DPBR_W18: begin row_o = addr_i[7:1]; lane = {addr_i[0], 1'b0}; multi = 1'b1; par = 1'b1; end
      DPBR_W32: begin row_o = addr_i[6:0]; multi = 1'b1; four = 1'b1; end
      DPBR_W36: begin row_o = addr_i[6:0]; multi = 1'b1; four = 1'b1; par = 1'b1; end
      default: ;
    endcase
    off = ({4'h0, lane} * 6'h09) + {3'h0, bo};
    mask_o = 36'h0;
    data_o = 36'h0;
    rd_o = 36'h0;
    if (!multi)
    begin
      // Narrow shapes write the whole word; byte enables are ignored.
      mask_o = nm << off;
      data_o = (wd_i & nm) << off;
      rd_o = (row_i >> off) & nm;
    end
    else
    begin
      ew = par ? 9 : 8;
      for (int i = 0; i < 4; i++)
      begin
        for (int j = 0; j < 9; j++)
        begin
          k = four ? i : i % 2;
          if ((j < ew) && (four || ((i / 2) == int'(lane[1]))))
          begin
            // Each enable gates its own lane only, eight or nine bits.
            mask_o[i * 9 + j] = be_i[k];
            data_o[i * 9 + j] = wd_i[k * ew + j];
            rd_o[k * ew + j] = row_i[i * 9 + j];
          end
        end
      end
    end
  end
endmodule

//--- hdl/dpbr_out_stage.sv
// Read data output register with bypass and immediate asynchronous clear.
`timescale 1ns/1ps
module dpbr_out_stage
  import dpbr_pkg::*;
#(
  parameter int W = 36
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic byp_i,
  input wire logic ld_i,
  input wire logic tick_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] lat_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] q_ff;

  // In bypass the flop tracks the array latch itself, so no extra cycle is added.
  always_ff @(posedge clk_i or negedge nrst_i or posedge clr_i)
  begin
    if (!nrst_i)
      q_ff <= '0;
    else if (clr_i)
      q_ff <= '0;
    else if (en_i)
    begin
      if (byp_i)
      begin
        if (ld_i)
          q_ff <= d_i;
      end
      else if (tick_i)
        q_ff <= lat_i;
    end
  end

  assign q_o = q_ff;
endmodule

//--- verif/dpbr_user_port.sv
// Model of the user logic that drives one port of the block RAM.
`timescale 1ns/1ps
module dpbr_user_port
  import dpbr_pkg::*;
(
  input wire logic clk_i,
  input wire logic [35:0] q_i,
  output logic ce_o,
  output logic clr_o,
  output logic oclr_o,
  output dpbr_req_t req_o
);
  // ****************************************
  // Port drive
  // ****************************************
  // Clears idle low; a scenario raises them by hand.
  initial
  begin
    ce_o = 1'b0;
    clr_o = 1'b0;
    oclr_o = 1'b0;
    req_o = '0;
  end
  // The request is held across its capture edge, then scrambled so a late sample shows.
  // The answer is taken two edges later, late enough for the registered output too.
  task automatic xfer(input logic ce, input logic we, input logic [11:0] a,
    input logic [3:0] be, input logic [35:0] d, output logic [35:0] q);
    begin
      @(negedge clk_i);
      req_o = '{we: we, addr: a, be: be, wdata: d};
      ce_o = ce;
      @(negedge clk_i);
      ce_o = 1'b0;
      req_o = ~req_o;
      repeat (2) @(negedge clk_i);
      q = q_i;
    end
  endtask
endmodule

//--- verif/dpbr_top_tb_top.sv
// Self-checking bench for the dual-port block RAM top.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module dpbr_top_tb_top
  import dpbr_pkg::*;
;
  logic clk, nrst, en, t0, t1, ld_we, err, full, empty;
  logic [6:0] ld_row;
  logic [35:0] ld_data, qa, qb, q;
  dpbr_cfg_t cfg;
  logic ce_a, clr_a, oclr_a, ce_b, clr_b, oclr_b;
  dpbr_req_t req_a, req_b;
  int mismatches, num_checks;
  always #50 clk = ~clk;
  dpbr_top i_dut (.clk_i(clk), .nrst_i(nrst), .en_i(en), .tick0_i(t0), .tick1_i(t1),
    .cfg_i(cfg), .ce_a_i(ce_a), .clr_a_i(clr_a), .oclr_a_i(oclr_a), .req_a_i(req_a),
    .ce_b_i(ce_b), .clr_b_i(clr_b), .oclr_b_i(oclr_b), .req_b_i(req_b),
    .load_we_i(ld_we), .load_row_i(ld_row), .load_data_i(ld_data), .q_a_o(qa),
    .q_b_o(qb), .cfg_err_o(err), .fifo_full_o(full), .fifo_empty_o(empty));
  dpbr_user_port pa (.clk_i(clk), .q_i(qa), .ce_o(ce_a), .clr_o(clr_a), .oclr_o(oclr_a),
    .req_o(req_a));
  dpbr_user_port pb (.clk_i(clk), .q_i(qb), .ce_o(ce_b), .clr_o(clr_b), .oclr_o(oclr_b),
    .req_o(req_b));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [35:0] lanes(input logic [3:0] m);
    logic [35:0] r;
    begin
      for (int i = 0; i < 4; i++)
        r[i*9 +: 9] = {9{m[i]}};
      return r;
    end
  endfunction
  task automatic final_report();
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Inputs and outputs run on opposite ticks so both selectors are exercised.
  task automatic setc(input dpbr_mode_t m, input dpbr_wc_t wa, input dpbr_wc_t wb,
    input logic byp, input logic exp);
    begin
      @(negedge clk);
      cfg = '{mode: m, wc_a: wa, wc_b: wb, in_sel_a: 1'b0, in_sel_b: 1'b1,
        out_sel_a: 1'b1, out_sel_b: 1'b0, byp_a: byp, byp_b: byp};
      repeat (2) @(negedge clk);
      `CHK("cfg_err", exp, err)
    end
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    #1000000;
    mismatches++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    en = 1'b1;
    t0 = 1'b1;
    t1 = 1'b1;
    ld_we = 1'b0;
    ld_row = '0;
    ld_data = '0;
    cfg = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(negedge clk);
    `CHK("q_a reset", 36'h0, qa)
    `CHK("empty reset", 1'b1, empty)
    nrst = 1'b1;
    $display("test reset done");
    setc(DPBR_M_TDP, DPBR_W36, DPBR_W36, 1'b1, 1'b1);
    setc(DPBR_M_TDP, DPBR_W32, DPBR_W16, 1'b1, 1'b1);
    setc(DPBR_M_SDP, DPBR_W8, DPBR_W9, 1'b1, 1'b1);
    setc(DPBR_M_TDP, DPBR_W16, DPBR_W1, 1'b1, 1'b0);
    $display("test config done");
    setc(DPBR_M_SDP, DPBR_W36, DPBR_W36, 1'b1, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      pa.xfer(1'b1, 1'b1, 12'h003, 4'hf, {36{1'b1}}, q);
      pa.xfer(1'b1, 1'b1, 12'h003, 4'(k), 36'h0, q);
      pb.xfer(1'b1, 1'b0, 12'h003, 4'h0, 36'h0, q);
      `CHK("masked row", lanes(~4'(k)), q)
    end
    $display("test byte enables done");
    pa.xfer(1'b1, 1'b1, 12'h003, 4'hf, {36{1'b1}}, q);
    pa.xfer(1'b0, 1'b1, 12'h003, 4'hf, 36'h0, q);
    pb.xfer(1'b1, 1'b1, 12'h003, 4'hf, 36'h0, q);
    pb.xfer(1'b1, 1'b0, 12'h003, 4'h0, 36'h0, q);
    `CHK("held row", {36{1'b1}}, q)
    @(negedge clk);
    pb.oclr_o = 1'b1;
    #1;
    `CHK("q_b cleared", 36'h0, qb)
    @(negedge clk);
    pb.oclr_o = 1'b0;
    $display("test hold and clear done");
    setc(DPBR_M_SDP, DPBR_W32, DPBR_W8, 1'b1, 1'b0);
    pa.xfer(1'b1, 1'b1, 12'h001, 4'hf, 36'h044332211, q);
    pa.xfer(1'b1, 1'b1, 12'h001, 4'h2, 36'h0ffffffff, q);
    for (int i = 0; i < 4; i++)
    begin
      pb.xfer(1'b1, 1'b0, 12'(4 + i), 4'h0, 36'h0, q);
      `CHK("byte", (i == 1) ? 8'hff : 8'(8'h11 * (i + 1)), q[7:0])
    end
    $display("test mixed width done");
    setc(DPBR_M_TDP, DPBR_W8, DPBR_W8, 1'b1, 1'b0);
    pa.xfer(1'b1, 1'b1, 12'h009, 4'h0, 36'h0a5, q);
    pb.xfer(1'b1, 1'b0, 12'h009, 4'h0, 36'h0, q);
    `CHK("narrow write", 8'ha5, q[7:0])
    $display("test narrow done");
    setc(DPBR_M_ROM, DPBR_W36, DPBR_W36, 1'b0, 1'b0);
    @(negedge clk);
    ld_we = 1'b1;
    ld_row = 7'h05;
    ld_data = 36'h123456789;
    @(negedge clk);
    ld_we = 1'b0;
    pa.xfer(1'b1, 1'b1, 12'h005, 4'hf, 36'h0, q);
    pa.xfer(1'b1, 1'b0, 12'h005, 4'h0, 36'h0, q);
    `CHK("rom word", 36'h123456789, q)
    @(negedge clk);
    t1 = 1'b0;
    ld_we = 1'b1;
    ld_data = 36'h0abcdef01;
    @(negedge clk);
    ld_we = 1'b0;
    pa.xfer(1'b1, 1'b0, 12'h005, 4'h0, 36'h0, q);
    `CHK("rom held", 36'h123456789, q)
    t1 = 1'b1;
    @(negedge clk);
    `CHK("rom ticked", 36'h0abcdef01, qa)
    $display("test rom done");
    setc(DPBR_M_FIFO, DPBR_W36, DPBR_W36, 1'b1, 1'b0);
    `CHK("fifo empty", 1'b1, empty)
    for (int i = 0; i < 128; i++)
      pa.xfer(1'b1, 1'b1, 12'h000, 4'hf, 36'(i + 1), q);
    `CHK("fifo full", 1'b1, full)
    pa.xfer(1'b1, 1'b1, 12'h000, 4'hf, 36'h0, q);
    for (int i = 0; i < 128; i++)
    begin
      pb.xfer(1'b1, 1'b0, 12'h000, 4'h0, 36'h0, q);
      `CHK("fifo word", 36'(i + 1), q)
    end
    `CHK("fifo drained", 1'b1, empty)
    `CHK("fifo not full", 1'b0, full)
    $display("test fifo done");
    setc(DPBR_M_SP, DPBR_W18, DPBR_W18, 1'b0, 1'b0);
    pa.xfer(1'b1, 1'b1, 12'h002, 4'h1, 36'h3ffff, q);
    pa.xfer(1'b1, 1'b0, 12'h002, 4'h0, 36'h0, q);
    `CHK("single port", 36'h001ff, q)
    pa.clr_o = 1'b1;
    @(negedge clk);
    `CHK("q_a in clear", 36'h001ff, qa)
    pa.clr_o = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("q_a after clear", 36'h0, qa)
    $display("test single port done");
    setc(DPBR_M_SHIFT, DPBR_W1, DPBR_W1, 1'b1, 1'b0);
    for (int i = 0; i < 130; i++)
    begin
      pa.xfer(1'b1, 1'b1, 12'h000, 4'h0, 36'(i), q);
      if (i >= 128)
        `CHK("tap0", 4'(i - 128), q[3:0])
    end
    $display("test shift done");
    final_report();
  end
endmodule
